/* dv/rioexp_master_model.sv */
// Serial-bus master model driving clock and data, one bit per 125 ns.
// Assumes the data wire is resolved outside with a pull-up.
`timescale 1ns/1ps
module rioexp_master_model (
  output logic scl, // Serial clock, idles high
  output logic sda_rel, // High releases the data wire
  input wire logic sda // Resolved data wire
);
  localparam realtime QT = 15.625ns;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // Entered with the clock low this makes a repeated start
  task automatic start();
    sda_rel = 1'b1;
    #(2*QT) scl = 1'b1;
    #(2*QT) sda_rel = 1'b0;
    #(2*QT) scl = 1'b0;
    #(2*QT);
  endtask
  task automatic stop();
    sda_rel = 1'b0;
    #(2*QT) scl = 1'b1;
    #(2*QT) sda_rel = 1'b1;
    #(4*QT);
  endtask
  task automatic bit_cycle(input logic b, output logic r);
    sda_rel = b;
    #(2*QT) scl = 1'b1;
    #(2*QT) r = sda;
    #(2*QT) scl = 1'b0;
    #(2*QT);
  endtask
  // Eight bits MSB first, then the acknowledge slot driven with m9
  task automatic xfer(input logic [7:0] d, input logic m9,
                      output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], q[i]);
    end
    bit_cycle(m9, a);
    ack = ~a;
  endtask
endmodule // rioexp_master_model

/* dv/rioexp_props.sv */
// Concurrent checks on the expander front's top-level ports.
// Assumes rioexp_top outputs settle within a few ref_clk cycles.
`timescale 1ns/1ps
module rioexp_props (
  input wire logic ref_clk, // System clock
  input wire logic rst_n, // Reset, active low
  input wire logic scl_in, // Serial clock level
  input wire logic sda_in, // Serial data level
  input wire logic sda_out, // Data drive value
  input wire logic sda_oe, // Data pull-down enable
  input wire logic addr_select_low, // Address pin 0
  input wire logic addr_select_high, // Address pin 1
  input wire logic [7:0] port_in, // Port line levels
  input wire logic [7:0] port_out, // Port latch
  input wire logic [7:0] port_oe, // Port pull-down enables
  input wire logic int_out, // Interrupt drive value
  input wire logic int_oe // Interrupt pull-down enable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] prev_in;
  logic [3:0] quiet;
  logic [3:0] next_quiet;
  // Cycles since the port lines last moved, saturating
  always_comb begin
    next_quiet = quiet;
    if (port_in != prev_in) begin
      next_quiet = 4'h0;
    end else if (quiet != 4'hF) begin
      next_quiet = quiet + 4'h1;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_in <= 8'h00;
      quiet <= 4'hF;
    end else begin
      prev_in <= port_in;
      quiet <= next_quiet;
    end
  end
  property p_oe_inv;
    $stable(port_out) |-> port_oe == ~port_out;
  endproperty
  a_oe_inv: assert property (p_oe_inv)
    else $error("port enables not inverse of latch");
  property p_drive_zero;
    (sda_oe || int_oe) |-> !sda_out && !int_out;
  endproperty
  a_drive_zero: assert property (p_drive_zero)
    else $error("open-drain pin driven high");
  property p_latch_scl;
    !$stable(port_out) && scl_in |-> port_out == 8'hFF;
  endproperty
  a_latch_scl: assert property (p_latch_scl)
    else $error("port latch moved with clock high");
  property p_int_set;
    $rose(int_oe) |-> quiet < 4'hA;
  endproperty
  a_int_set: assert property (p_int_set)
    else $error("interrupt without port change");
  property p_int_keep;
    $rose(int_oe) |-> int_oe [*4];
  endproperty
  a_int_keep: assert property (p_int_keep)
    else $error("interrupt pulse too short");
  property p_int_clr;
    $fell(int_oe) |-> !scl_in;
  endproperty
  a_int_clr: assert property (p_int_clr)
    else $error("interrupt cleared outside a transfer");
  property p_sda_chg;
    !$stable(sda_oe) |-> !scl_in;
  endproperty
  a_sda_chg: assert property (p_sda_chg)
    else $error("data drive changed with clock high");
  property p_rst_rel;
    $rose(rst_n) |-> port_out == 8'hFF && port_oe == 8'h00 && !int_oe && !sda_oe;
  endproperty
  a_rst_rel: assert property (p_rst_rel)
    else $error("outputs not at reset values");
  c_write: cover property (!$stable(port_out));
  c_int: cover property ($rose(int_oe));
  c_ack: cover property ($rose(sda_oe));
endmodule // rioexp_props

bind rioexp_top rioexp_props i_rioexp_props (.ref_clk, .rst_n, .scl_in,
  .sda_in, .sda_out, .sda_oe, .addr_select_low, .addr_select_high,
  .port_in, .port_out, .port_oe, .int_out, .int_oe);

/* dv/test_rioexp_top.sv */
// Self-checking bench for rioexp_top with a serial-bus master model.
// Assumes port lines are weak-high unless the device pulls them low.
`timescale 1ns/1ps
module test_rioexp_top;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] ext = 8'hFF;
  logic [1:0] tie_h = 2'h0;
  logic [1:0] tie_l = 2'h0;
  logic scl, sda_rel, sda_w, sel_l, sel_h, sda_out, sda_oe, int_out, int_oe;
  logic [7:0] port_in, port_out, port_oe, q, d;
  logic a1, a2;
  logic [6:0] me;
  int err_count = 0;
  int samples_checked = 0;
  always #2 ref_clk = ~ref_clk;
  assign sda_w = sda_rel & ~sda_oe;
  assign port_in = ext & ~port_oe;
  assign sel_l = tie_l[1] ? (tie_l[0] ? sda_w : scl) : tie_l[0];
  assign sel_h = tie_h[1] ? (tie_h[0] ? sda_w : scl) : tie_h[0];
  rioexp_master_model i_rioexp_master_model (.scl, .sda_rel, .sda(sda_w));
  rioexp_top i_rioexp_top (.ref_clk, .rst_n, .scl_in(scl), .sda_in(sda_w),
    .sda_out, .sda_oe, .addr_select_low(sel_l), .addr_select_high(sel_h),
    .port_in, .port_out, .port_oe, .int_out, .int_oe);
  // Tie codes: 0 ground, 1 supply, 2 clock line, 3 data line
  function automatic logic [6:0] exp_addr(input logic [1:0] h,
                                          input logic [1:0] l);
    logic [6:0] b;
    b = h[1] ? (l[1] ? 7'h18 : 7'h10) : (l[1] ? 7'h28 : 7'h20);
    return b | {5'h00, h[0], l[0]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      err_count++;
    end
  endtask
  task automatic end_of_test();
    $display("checked %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Header byte, then one byte; reads send all ones and nack it
  task automatic txn(input logic [7:0] hd, input logic [7:0] dv);
    i_rioexp_master_model.start();
    i_rioexp_master_model.xfer(hd, 1'b1, q, a1);
    i_rioexp_master_model.xfer(dv, 1'b1, q, a2);
    i_rioexp_master_model.stop();
  endtask
  task automatic wait_int();
    for (int i = 0; i < 50 && int_oe !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    check(8'(int_oe), 8'h01);
    if (int_oe !== 1'b1) begin
      end_of_test();
    end
  endtask
  initial begin
    d = 8'($urandom(32'hFF2A));
    tie_h = 2'($urandom);
    tie_l = 2'($urandom);
    me = exp_addr(tie_h, tie_l);
    repeat (8) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (12) @(posedge ref_clk);
    check(port_out, 8'hFF);
    check(port_oe, 8'h00);
    check({6'h00, int_oe, sda_oe}, 8'h00);
    i_rioexp_master_model.start();
    i_rioexp_master_model.stop();
    for (int k = 0; k < 2; k++) begin
      d = (k == 0) ? 8'h00 : 8'($urandom);
      txn({me, 1'b0}, d);
      check({6'h00, a1, a2}, 8'h03);
      check(port_out, d);
      check(port_oe, ~d);
    end
    txn({me ^ 7'h01, 1'b0}, ~d);
    check({6'h00, a1, a2}, 8'h00);
    check(port_out, d);
    txn({me, 1'b0}, 8'hFF);
    txn({me, 1'b1}, 8'hFF);
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      #1 ext = ext ^ (8'($urandom) | 8'h01);
      wait_int();
      txn({me, 1'b1}, 8'hFF);
      check(8'(a1), 8'h01);
      check(q, ext);
      check(8'(int_oe), 8'h00);
    end
    txn({me, 1'b0}, 8'h5A);
    txn(8'h01, 8'hFF);
    check(8'(a1), 8'h00);
    txn(8'h00, 8'h07);
    check({6'h00, a1, a2}, 8'h02);
    i_rioexp_master_model.start();
    i_rioexp_master_model.xfer(8'h00, 1'b1, q, a1);
    i_rioexp_master_model.xfer(8'h06, 1'b1, q, a2);
    i_rioexp_master_model.start();
    i_rioexp_master_model.stop();
    check(port_out, 8'h5A);
    txn(8'h00, 8'h06);
    check({6'h00, a1, a2}, 8'h03);
    check(port_out, 8'hFF);
    txn({me, 1'b0}, 8'h3C);
    @(posedge ref_clk);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    check(port_out, 8'hFF);
    check(port_oe, 8'h00);
    #1 rst_n = 1'b1;
    repeat (12) @(posedge ref_clk);
    check(port_out, 8'hFF);
    check(8'(int_oe), 8'h00);
    end_of_test();
  end
endmodule // test_rioexp_top

/* hdl/rioexp_strap.sv */
// Works out how each address-select pin is tied and the address it gives.
// Assumes filtered levels, all delayed alike, from the core.
`timescale 1ns/1ps
module rioexp_strap
  import rioexp_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronised reset, active low
  rioexp_strap_if.strap bus // Filtered levels in, address out
);

  logic [1:0] diff_scl;
  logic [1:0] diff_sda;
  logic scl_low_seen;
  logic sda_low_seen;
  logic [6:0] slave_addr;
  logic [1:0] next_diff_scl;
  logic [1:0] next_diff_sda;
  logic next_scl_low_seen;
  logic next_sda_low_seen;
  logic [6:0] next_slave_addr;
  logic [1:0] pins;

  // A pin that never disagreed with a moving bus line is tied to it
  function automatic rioexp_tie_type tie_of(input logic level,
                                            input logic dscl,
                                            input logic dsda,
                                            input logic scl_seen,
                                            input logic sda_seen);
    if (scl_seen && !dscl) begin
      return RIOEXP_TIE_SCL;
    end else if (sda_seen && !dsda) begin
      return RIOEXP_TIE_SDA;
    end else if (level) begin
      return RIOEXP_TIE_VDD;
    end
    return RIOEXP_TIE_VSS;
  endfunction

  always_comb begin
    pins = {bus.sel_high, bus.sel_low};
    next_diff_scl = diff_scl | (pins ^ {2{bus.scl}});
    next_diff_sda = diff_sda | (pins ^ {2{bus.sda}});
    next_scl_low_seen = scl_low_seen | ~bus.scl;
    next_sda_low_seen = sda_low_seen | ~bus.sda;
    next_slave_addr = rioexp_addr_of(
      tie_of(pins[1], diff_scl[1], diff_sda[1], scl_low_seen, sda_low_seen),
      tie_of(pins[0], diff_scl[0], diff_sda[0], scl_low_seen, sda_low_seen));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      diff_scl <= 2'h0;
      diff_sda <= 2'h0;
      scl_low_seen <= 1'b0;
      sda_low_seen <= 1'b0;
      slave_addr <= RIOEXP_BASE_RAIL_RAIL;
    end else begin
      diff_scl <= next_diff_scl;
      diff_sda <= next_diff_sda;
      scl_low_seen <= next_scl_low_seen;
      sda_low_seen <= next_sda_low_seen;
      slave_addr <= next_slave_addr;
    end
  end

  assign bus.slave_addr = slave_addr;

endmodule // rioexp_strap

/* hdl/rioexp_top.sv */
// Serial-bus slave front of the 8-bit quasi-bidirectional expander.
// Assumes ref_clk is at least thirty times the serial clock; all pins
// are asynchronous, and all but rst_n pass a three-stage filter before use.
`timescale 1ns/1ps
module rioexp_top
  import rioexp_pkg::*;
(
  input wire logic ref_clk, // System clock, 250 MHz
  input wire logic rst_n, // Hardware reset pin, active low
  input wire logic scl_in, // Serial clock level
  input wire logic sda_in, // Serial data level
  output logic sda_out, // Serial data drive value, always low
  output logic sda_oe, // Serial data pulled low while high
  input wire logic addr_select_low, // Address select pin 0 level
  input wire logic addr_select_high, // Address select pin 1 level
  input wire logic [7:0] port_in, // Port line levels
  output logic [7:0] port_out, // Port output latch
  output logic [7:0] port_oe, // Port line pulled low while high
  output logic int_out, // Interrupt drive value, always low
  output logic int_oe // Interrupt line pulled low while high
);

  localparam int NIN = 12;

  logic rst_meta_n;
  logic rst_sync_n;
  logic [NIN-1:0] s1;
  logic [NIN-1:0] s2;
  logic [NIN-1:0] s3;
  logic [NIN-1:0] filt;
  logic [NIN-1:0] next_filt;
  logic scl_q;
  logic sda_q;
  logic scl_f;
  logic sda_f;
  logic [7:0] port_f;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  rioexp_state_type state;
  rioexp_state_type next_state;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [7:0] latch;
  logic [7:0] next_latch;
  logic drive;
  logic next_drive;
  logic [7:0] snap;
  logic [7:0] next_snap;
  logic [4:0] primed;
  logic [4:0] next_primed;
  logic irq;
  logic next_irq;
  logic irq_clr;
  logic [7:0] byte_in;

  rioexp_strap_if strap_bus ();

  // Reset pin released through two flops; the software reset reloads only the port latch
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // A bit changes once the second and third stages agree
  always_comb begin
    next_filt = filt;
    for (int i = 0; i < NIN; i++) begin
      if (s2[i] == s3[i]) begin
        next_filt[i] = s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
      filt <= '1;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      s1 <= {addr_select_high, addr_select_low, port_in, sda_in, scl_in};
      s2 <= s1;
      s3 <= s2;
      filt <= next_filt;
      scl_q <= filt[0];
      sda_q <= filt[1];
    end
  end

  assign scl_f = filt[0];
  assign sda_f = filt[1];
  assign port_f = filt[9:2];
  assign scl_rise = scl_f && !scl_q;
  assign scl_fall = !scl_f && scl_q;
  // Edges found by oversampling, good for serial clocks up to 1 MHz
  assign start_ev = scl_f && scl_q && !sda_f && sda_q;
  assign stop_ev = scl_f && scl_q && sda_f && !sda_q;
  assign byte_in = {shift[6:0], sda_f};

  assign strap_bus.scl = scl_f;
  assign strap_bus.sda = sda_f;
  assign strap_bus.sel_low = filt[10];
  assign strap_bus.sel_high = filt[11];

  rioexp_strap u_strap (
    .clk(ref_clk),
    .rst_n(rst_sync_n),
    .bus(strap_bus)
  );

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shift = shift;
    next_latch = latch;
    next_drive = drive;
    irq_clr = 1'b0;
    if (start_ev) begin
      next_state = RIOEXP_ADDR;
      next_cnt = 3'h0;
      next_drive = 1'b0;
    end else if (stop_ev) begin
      if (state == RIOEXP_SR_WAIT) begin
        next_latch = RIOEXP_LATCH_RESET;
      end
      next_state = RIOEXP_IDLE;
      next_drive = 1'b0;
    end else begin
      case (state)
        RIOEXP_ADDR, RIOEXP_WR_BYTE, RIOEXP_SR_BYTE: begin
          if (scl_rise) begin
            next_shift = byte_in;
            next_cnt = cnt + RIOEXP_BIT_STEP;
            if (cnt == RIOEXP_LAST_BIT) begin
              next_state = RIOEXP_IGNORE;
              if (state == RIOEXP_WR_BYTE) begin
                next_state = RIOEXP_WR_ACK;
              end else if (state == RIOEXP_SR_BYTE) begin
                if (byte_in == RIOEXP_SRST_CODE) begin
                  next_state = RIOEXP_SR_ACK;
                end
              end else if (byte_in[7:1] == strap_bus.slave_addr) begin
                next_state = RIOEXP_ADDR_ACK;
              end else if (byte_in == RIOEXP_GCALL_WRITE) begin
                next_state = RIOEXP_GC_ACK;
              end
            end
          end
        end
        RIOEXP_ADDR_ACK, RIOEXP_GC_ACK, RIOEXP_WR_ACK, RIOEXP_SR_ACK: begin
          // First fall pulls data low, second fall ends the acknowledge
          if (scl_fall && !drive) begin
            next_drive = 1'b1;
          end else if (scl_fall) begin
            next_drive = 1'b0;
            next_cnt = 3'h0;
            case (state)
              RIOEXP_ADDR_ACK: begin
                if (shift[0]) begin
                  next_shift = port_f;
                  next_drive = ~port_f[7];
                  irq_clr = 1'b1;
                  next_state = RIOEXP_RD_BYTE;
                end else begin
                  next_state = RIOEXP_WR_BYTE;
                end
              end
              RIOEXP_GC_ACK: next_state = RIOEXP_SR_BYTE;
              RIOEXP_WR_ACK: begin
                next_latch = shift;
                irq_clr = 1'b1;
                next_state = RIOEXP_WR_BYTE;
              end
              default: next_state = RIOEXP_SR_WAIT;
            endcase
          end
        end
        RIOEXP_RD_BYTE: begin
          if (scl_fall) begin
            next_cnt = cnt + RIOEXP_BIT_STEP;
            next_shift = {shift[6:0], 1'b0};
            next_drive = ~shift[6];
            if (cnt == RIOEXP_LAST_BIT) begin
              next_drive = 1'b0;
              next_state = RIOEXP_RD_ACK;
            end
          end
        end
        RIOEXP_RD_ACK: begin
          if (scl_rise) begin
            next_state = sda_f ? RIOEXP_IGNORE : RIOEXP_RD_NEXT;
          end
        end
        RIOEXP_RD_NEXT: begin
          if (scl_fall) begin
            next_shift = port_f;
            next_drive = ~port_f[7];
            irq_clr = 1'b1;
            next_cnt = 3'h0;
            next_state = RIOEXP_RD_BYTE;
          end
        end
        RIOEXP_SR_WAIT: begin
          // A further byte aborts the reset and is not acknowledged; a stop
          // raises the clock first too, so a falling clock or a new start aborts
          if (scl_fall) begin
            next_state = RIOEXP_IGNORE;
          end
        end
        default: next_state = state;
      endcase
    end
  end

  // A port change raises the line until a read or write clears it; a
  // change in the clearing cycle keeps it raised. Changes count only once
  // the filter shows the pins, so reset itself raises nothing.
  always_comb begin
    next_primed = {primed[3:0], 1'b1};
    next_snap = port_f;
    next_irq = (irq && !irq_clr) || (primed[4] && (port_f != snap));
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= RIOEXP_IDLE;
      cnt <= 3'h0;
      shift <= 8'h00;
      latch <= RIOEXP_LATCH_RESET;
      drive <= 1'b0;
      snap <= RIOEXP_LATCH_RESET;
      primed <= 5'h00;
      irq <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      port_out <= RIOEXP_LATCH_RESET;
      port_oe <= 8'h00;
      int_out <= 1'b0;
      int_oe <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shift <= next_shift;
      latch <= next_latch;
      drive <= next_drive;
      snap <= next_snap;
      primed <= next_primed;
      irq <= next_irq;
      sda_out <= 1'b0;
      sda_oe <= next_drive;
      port_out <= next_latch;
      port_oe <= ~next_latch;
      int_out <= 1'b0;
      int_oe <= next_irq;
    end
  end

endmodule // rioexp_top

/* include/rioexp_pkg.sv */
// Constants, types and address decoding for the remote I/O expander front.
// Assumes a system clock far faster than the 1 MHz serial clock.
// What this block does
// - Answer one of 16 addresses from two pins.
// - Direction bit one reads, zero writes.
// - Any reset source returns port lines to inputs.
// - Hardware reset pin is active low.
// - Raise interrupt when port input data changes.
// - Interrupt is open-drain, pulled low when active.
// - Eight-bit latched quasi-bidirectional port.
// - Works with serial clock up to 1 MHz.
// - General call plus 06h then stop resets.
// - Port latches hold high after power-on.
package rioexp_pkg;

  localparam logic [7:0] RIOEXP_LATCH_RESET = 8'hFF;
  localparam logic [7:0] RIOEXP_GCALL_WRITE = 8'h00;
  localparam logic [7:0] RIOEXP_SRST_CODE = 8'h06;
  localparam logic [2:0] RIOEXP_LAST_BIT = 3'h7;
  localparam logic [2:0] RIOEXP_BIT_STEP = 3'h1;
  localparam logic [6:0] RIOEXP_BASE_BUS_RAIL = 7'h10;
  localparam logic [6:0] RIOEXP_BASE_BUS_BUS = 7'h18;
  localparam logic [6:0] RIOEXP_BASE_RAIL_RAIL = 7'h20;
  localparam logic [6:0] RIOEXP_BASE_RAIL_BUS = 7'h28;

  typedef enum logic [1:0] {
    RIOEXP_TIE_VSS,
    RIOEXP_TIE_VDD,
    RIOEXP_TIE_SCL,
    RIOEXP_TIE_SDA
  } rioexp_tie_type;

  typedef enum logic [3:0] {
    RIOEXP_IDLE,
    RIOEXP_ADDR,
    RIOEXP_ADDR_ACK,
    RIOEXP_GC_ACK,
    RIOEXP_WR_BYTE,
    RIOEXP_WR_ACK,
    RIOEXP_RD_BYTE,
    RIOEXP_RD_ACK,
    RIOEXP_RD_NEXT,
    RIOEXP_SR_BYTE,
    RIOEXP_SR_ACK,
    RIOEXP_SR_WAIT,
    RIOEXP_IGNORE
  } rioexp_state_type;

  function automatic logic is_bus_tie(input rioexp_tie_type t);
    return (t == RIOEXP_TIE_SCL) || (t == RIOEXP_TIE_SDA);
  endfunction

  // Seven-bit address from the two pin ties
  function automatic logic [6:0] rioexp_addr_of(input rioexp_tie_type hi,
                                                 input rioexp_tie_type lo);
    logic [6:0] base;
    logic bit1;
    logic bit0;
    base = RIOEXP_BASE_RAIL_RAIL;
    bit1 = is_bus_tie(hi) ? (hi == RIOEXP_TIE_SDA) : (hi == RIOEXP_TIE_VDD);
    bit0 = is_bus_tie(lo) ? (lo == RIOEXP_TIE_SDA) : (lo == RIOEXP_TIE_VDD);
    if (is_bus_tie(hi) && is_bus_tie(lo)) begin
      base = RIOEXP_BASE_BUS_BUS;
    end else if (is_bus_tie(hi)) begin
      base = RIOEXP_BASE_BUS_RAIL;
    end else if (is_bus_tie(lo)) begin
      base = RIOEXP_BASE_RAIL_BUS;
    end
    return base | {5'h00, bit1, bit0};
  endfunction

endpackage

/* include/rioexp_strap_if.sv */
// Carries the filtered bus and select levels to the address classifier
// and the resolved slave address back to the core.
`timescale 1ns/1ps
interface rioexp_strap_if;
  logic scl;
  logic sda;
  logic sel_low;
  logic sel_high;
  logic [6:0] slave_addr;
  modport core (output scl, output sda, output sel_low, output sel_high,
                input slave_addr);
  modport strap (input scl, input sda, input sel_low, input sel_high,
                 output slave_addr);
endinterface
